/* mbrf_slave.sv */
// Slave end: parses queries, checks the error check, executes and replies.
`timescale 1ns/100ps
module mbrf_slave
   import mbrf_pkg::*;
#(
   parameter int REG_ADDR_W = 13
)
(
   input wire logic clk,
   input wire logic rst_n,
   mbrf_link_if.slave_end link,
   input wire logic [7:0] slave_addr,
   output logic busy,
   output logic [15:0] wr_addr,
   output logic [15:0] wr_data,
   output logic wr_strobe
);
   // ****************************************
   // Storage
   // ****************************************
   logic [15:0] regs [0:(1 << REG_ADDR_W) - 1];
   logic [7:0] qbuf [0:QUERY_LEN - 1];
   logic [7:0] rbuf [0:REPLY_MAX - 1];
   logic [3:0] qcnt;
   logic qover;
   logic [15:0] qcrc;
   logic [5:0] rlen;
   logic [5:0] ridx;
   logic [4:0] rd_k;
   logic [15:0] rcrc;

   typedef enum logic [2:0] {ST_RX, ST_EXEC, ST_READ, ST_CRC, ST_SEND} mbrf_state_t;
   mbrf_state_t state;

   logic [7:0] fn;
   logic [15:0] f_a;
   logic [15:0] f_b;
   logic [16:0] span;
   assign fn = qbuf[1];
   assign f_a = {qbuf[2], qbuf[3]};
   assign f_b = {qbuf[4], qbuf[5]};
   assign span = {1'b0, f_a} + {1'b0, f_b};

   // ****************************************
   // Query reception
   // ****************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         qcnt <= 4'h0;
         qover <= 1'b0;
         qcrc <= CRC_INIT;
      end
      else if (state == ST_RX && link.q_valid)
      begin
         if (link.q_last)
         begin
            qcnt <= 4'h0;
            qover <= 1'b0;
            qcrc <= CRC_INIT;
         end
         else
         begin
            if (qcnt < 4'(QUERY_LEN))
               qcnt <= qcnt + 4'h1;
            else
               qover <= 1'b1;
            qcrc <= mbrf_crc_byte(qcrc, link.q_data);
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (state == ST_RX && link.q_valid && qcnt < 4'(QUERY_LEN))
         qbuf[qcnt[2:0]] <= link.q_data;
   end

   // ****************************************
   // Execution and reply
   // ****************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ST_RX;
         rlen <= 6'h00;
         ridx <= 6'h00;
         rd_k <= 5'h00;
         rcrc <= CRC_INIT;
         wr_strobe <= 1'b0;
         wr_addr <= 16'h0000;
         wr_data <= 16'h0000;
         busy <= 1'b0;
      end
      else
      begin
         wr_strobe <= 1'b0;
         case (state)
            ST_RX:
            begin
               busy <= 1'b0;
               // last byte is CRC upper; full residue check
               if (link.q_valid && link.q_last)
               begin
                  if (qcnt == 4'(QUERY_LEN - 1) && !qover && qbuf[0] == slave_addr
                      && mbrf_crc_byte(qcrc, link.q_data) == 16'h0000)
                  begin
                     state <= ST_EXEC;
                     busy <= 1'b1;
                  end
               end
            end
            ST_EXEC:
            begin
               rbuf[0] <= qbuf[0];
               rbuf[1] <= fn;
               rcrc <= CRC_INIT;
               ridx <= 6'h00;
               state <= ST_CRC;
               rlen <= 6'd3;
               rbuf[1] <= fn | FN_EXC_FLAG;
               if (fn != FN_READ_HOLD && fn != FN_WRITE_ONE && fn != FN_DIAG)
                  rbuf[2] <= EXC_BAD_FUNC;
               else if (fn == FN_DIAG && f_a != DIAG_SUB_ECHO)
                  rbuf[2] <= EXC_BAD_FUNC;
               else if (fn == FN_READ_HOLD && (f_b == 16'h0000 || f_b > MAX_READ_COUNT))
                  rbuf[2] <= EXC_BAD_DATA;
               else if (f_a >= ADDR_LIMIT || (fn == FN_READ_HOLD && span >= {1'b0, ADDR_LIMIT}))
                  rbuf[2] <= EXC_BAD_ADDR;
               else if (fn == FN_READ_HOLD)
               begin
                  rbuf[1] <= fn;
                  rbuf[2] <= {f_b[6:0], 1'b0};
                  rlen <= 6'd3;
                  rd_k <= 5'h00;
                  state <= ST_READ;
               end
               else
               begin
                  rbuf[1] <= fn;
                  for (int i = 2; i < 6; i++)
                     rbuf[i] <= qbuf[i];
                  rlen <= 6'd6;
                  if (fn == FN_WRITE_ONE)
                  begin
                     wr_strobe <= 1'b1;
                     wr_addr <= f_a;
                     wr_data <= f_b;
                  end
               end
            end
            ST_READ:
            begin
               rbuf[rlen] <= regs[REG_ADDR_W'(f_a + 16'(rd_k))][15:8];
               rbuf[rlen + 6'd1] <= regs[REG_ADDR_W'(f_a + 16'(rd_k))][7:0];
               rlen <= rlen + 6'd2;
               rd_k <= rd_k + 5'h01;
               if (16'(rd_k) + 16'h0001 == f_b)
                  state <= ST_CRC;
            end
            ST_CRC:
            begin
               // reply CRC computed over preceding bytes
               if (ridx < rlen)
               begin
                  rcrc <= mbrf_crc_byte(rcrc, rbuf[ridx]);
                  ridx <= ridx + 6'h01;
               end
               else
               begin
                  rbuf[rlen] <= rcrc[7:0];
                  rbuf[rlen + 6'd1] <= rcrc[15:8];
                  rlen <= rlen + 6'd2;
                  ridx <= 6'h00;
                  state <= ST_SEND;
               end
            end
            ST_SEND:
            begin
               ridx <= ridx + 6'h01;
               if (ridx + 6'h01 == rlen)
                  state <= ST_RX;
            end
            default:
               state <= ST_RX;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (wr_strobe)
         regs[REG_ADDR_W'(wr_addr)] <= wr_data;
   end

   // ****************************************
   // Reply byte output
   // ****************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         link.r_valid <= 1'b0;
         link.r_last <= 1'b0;
         link.r_data <= 8'h00;
      end
      else
      begin
         link.r_valid <= (state == ST_SEND);
         link.r_last <= (state == ST_SEND) && (ridx + 6'h01 == rlen);
         link.r_data <= rbuf[ridx];
      end
   end
endmodule

/* mbrf_pkg.sv */
// Package of shared constants and the CRC byte function for the register function handler.
package mbrf_pkg;
   localparam logic [7:0] FN_READ_HOLD = 8'h03;
   localparam logic [7:0] FN_WRITE_ONE = 8'h06;
   localparam logic [7:0] FN_DIAG = 8'h08;
   localparam logic [7:0] FN_EXC_FLAG = 8'h80;
   localparam logic [15:0] DIAG_SUB_ECHO = 16'h0000;
   localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
   localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
   localparam logic [7:0] EXC_BAD_DATA = 8'h03;
   localparam logic [15:0] ADDR_LIMIT = 16'h2000;
   localparam logic [15:0] MAX_READ_COUNT = 16'h0010;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam int QUERY_LEN = 8;
   localparam int REPLY_MAX = 37;
   localparam logic [7:0] DEFAULT_SLAVE_ADDR = 8'h01;
   // The longest reply starts about 55 cycles after the last query byte.
   // A master that hears nothing for this long treats the query as dropped.
   localparam int REPLY_TIMEOUT = 100;

   function automatic logic [15:0] mbrf_crc_byte(input logic [15:0] crc, input logic [7:0] data);
      logic [15:0] c;
      c = crc ^ {8'h00, data};
      for (int i = 0; i < 8; i++)
      begin
         if (c[0])
            c = (c >> 1) ^ CRC_POLY;
         else
            c = c >> 1;
      end
      return c;
   endfunction
endpackage

/* mbrf_link_if.sv */
// Interface carrying the serial byte stream between master and slave ends.
`timescale 1ns/100ps
interface mbrf_link_if;
   logic [7:0] q_data;
   logic q_valid;
   logic q_last;
   logic [7:0] r_data;
   logic r_valid;
   logic r_last;
   modport slave_end (input q_data, input q_valid, input q_last, output r_data, output r_valid, output r_last);
   modport master_end (output q_data, output q_valid, output q_last, input r_data, input r_valid, input r_last);
endinterface

/* mbrf_master.sv */
// Master end: sends one query with CRC and collects the reply.
`timescale 1ns/100ps
module mbrf_master
   import mbrf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   mbrf_link_if.master_end link,
   input wire logic start,
   input wire logic [7:0] q_slave,
   input wire logic [7:0] q_func,
   input wire logic [15:0] q_field_a,
   input wire logic [15:0] q_field_b,
   output logic busy,
   output logic done,
   output logic crc_ok,
   output logic [7:0] rx_byte,
   output logic rx_valid
);
   typedef enum logic [1:0] {MS_IDLE, MS_SEND, MS_WAIT} mbrf_mstate_t;
   mbrf_mstate_t state;
   logic [7:0] frame [0:5];
   logic [2:0] idx;
   logic [15:0] tcrc;
   logic [15:0] rcrc;
   logic [7:0] wait_cnt;

   // ****************************************
   // Query transmission
   // ****************************************
   // fields sent upper byte first; CRC low byte first.
   // pairing of 32-bit halves is left to the command source.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= MS_IDLE;
         idx <= 3'h0;
         tcrc <= CRC_INIT;
         busy <= 1'b0;
         wait_cnt <= 8'h00;
         link.q_valid <= 1'b0;
         link.q_last <= 1'b0;
         link.q_data <= 8'h00;
      end
      else
      begin
         link.q_valid <= 1'b0;
         link.q_last <= 1'b0;
         case (state)
            MS_IDLE:
               if (start)
               begin
                  frame[0] <= q_slave;
                  frame[1] <= q_func;
                  frame[2] <= q_field_a[15:8];
                  frame[3] <= q_field_a[7:0];
                  frame[4] <= q_field_b[15:8];
                  frame[5] <= q_field_b[7:0];
                  idx <= 3'h0;
                  tcrc <= CRC_INIT;
                  busy <= 1'b1;
                  wait_cnt <= 8'h00;
                  state <= MS_SEND;
               end
            MS_SEND:
            begin
               link.q_valid <= 1'b1;
               idx <= idx + 3'h1;
               if (idx < 3'd6)
               begin
                  link.q_data <= frame[idx];
                  tcrc <= mbrf_crc_byte(tcrc, frame[idx]);
               end
               else if (idx == 3'd6)
                  link.q_data <= tcrc[7:0];
               else
               begin
                  link.q_data <= tcrc[15:8];
                  link.q_last <= 1'b1;
                  state <= MS_WAIT;
               end
            end
            MS_WAIT:
            begin
               wait_cnt <= wait_cnt + 8'h01;
               if (link.r_valid)
                  wait_cnt <= 8'h00;
               if (link.r_valid && link.r_last)
               begin
                  busy <= 1'b0;
                  state <= MS_IDLE;
               end
               else if (!link.r_valid && wait_cnt == 8'(REPLY_TIMEOUT))
               begin
                  busy <= 1'b0;
                  state <= MS_IDLE;
               end
            end
            default:
               state <= MS_IDLE;
         endcase
      end
   end

   // ****************************************
   // Reply collection
   // ****************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rcrc <= CRC_INIT;
         done <= 1'b0;
         crc_ok <= 1'b0;
         rx_byte <= 8'h00;
         rx_valid <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         rx_valid <= link.r_valid;
         rx_byte <= link.r_data;
         if (link.r_valid)
         begin
            // residue of whole reply is zero when CRC matches
            if (link.r_last)
            begin
               rcrc <= CRC_INIT;
               done <= 1'b1;
               crc_ok <= (mbrf_crc_byte(rcrc, link.r_data) == 16'h0000);
            end
            else
               rcrc <= mbrf_crc_byte(rcrc, link.r_data);
         end
      end
   end
endmodule

/* mbrf_asserts.sv */
// Checker of the byte link between the master and slave ends.
`timescale 1ns/100ps
module mbrf_asserts
   import mbrf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] q_data,
   input wire logic q_valid,
   input wire logic q_last,
   input wire logic [7:0] r_data,
   input wire logic r_valid,
   input wire logic r_last
);
   logic [2:0] q_idx;
   logic [5:0] r_idx;
   logic [7:0] q_addr;
   logic [7:0] q_fn;
   logic [15:0] q_cnt;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         q_idx <= 3'h0;
      else if (q_valid)
         q_idx <= q_last ? 3'h0 : q_idx + 3'h1;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         r_idx <= 6'h00;
      else if (r_valid)
         r_idx <= r_last ? 6'h00 : r_idx + 6'h01;
   end
   // Fields are kept unreset, as they are only read once a reply runs.
   always_ff @(posedge clk)
   begin
      if (q_valid && q_idx == 3'h0)
         q_addr <= q_data;
      if (q_valid && q_idx == 3'h1)
         q_fn <= q_data;
      if (q_valid && q_idx == 3'h4)
         q_cnt[15:8] <= q_data;
      if (q_valid && q_idx == 3'h5)
         q_cnt[7:0] <= q_data;
   end
   query_len_a: assert property (q_valid && q_last |-> q_idx == 3'h7)
      else $error("query frame is not eight bytes");
   last_flag_a: assert property (r_last |-> r_valid)
      else $error("reply end flag without data");
   reply_run_a: assert property (r_valid && !r_last |=> r_valid)
      else $error("reply stream broken");
   no_overlap_a: assert property (q_valid |-> !r_valid)
      else $error("reply during query");
   reply_addr_a: assert property (r_valid && r_idx == 6'h00 |-> r_data == q_addr)
      else $error("reply address differs from query");
   reply_func_a: assert property (r_valid && r_idx == 6'h01
      |-> r_data == q_fn || r_data == (q_fn | FN_EXC_FLAG))
      else $error("reply function code wrong");
   exc_shape_a: assert property (r_valid && r_idx == 6'h01 && r_data[7] |=> !r_last [*2] ##1 r_last)
      else $error("exception reply length wrong");
   exc_code_a: assert property (r_valid && r_idx == 6'h01 && r_data[7]
      |=> r_data inside {8'h01, 8'h02, 8'h03})
      else $error("exception code out of set");
   read_count_a: assert property (r_valid && r_idx == 6'h01 && r_data == FN_READ_HOLD
      |=> r_data == 8'(q_cnt << 1))
      else $error("read byte count wrong");
   echo_len_a: assert property (r_valid && r_idx == 6'h01
      && (r_data == FN_WRITE_ONE || r_data == FN_DIAG) |=> !r_last [*5] ##1 r_last)
      else $error("echo reply length wrong");
endmodule

/* mbrf_test.sv */
// Testbench joining the master and slave ends, with a second slave fed by a faulty sender.
`timescale 1ns/100ps
`define CHK(a, b) \
   begin \
      total_checks++; \
      if ((a) !== (b)) \
      begin \
         n_errors++; \
         $display("[FAIL] %0t mismatch", $time); \
      end \
   end
module mbrf_test
   import mbrf_pkg::*;
;
   logic clk, rst_n, start, done, crc_ok, rx_valid, wr_strobe, got_done;
   logic m_busy, s_busy, s_seen;
   logic [7:0] q_slave, q_func, rx_byte, s_addr;
   logic [15:0] fa, fb, wr_addr, wr_data, wa, wd, c;
   logic [7:0] rq[$], e[$], g[$], h[$];
   logic [15:0] dv [4] = '{16'h0000, 16'h0064, 16'h0000, 16'h0FA0};
   // Function, address, count or value, expected exception code.
   logic [47:0] xt [9] = '{48'h03_0000_0000_03, 48'h03_0000_0011_03, 48'h03_1FF0_0010_02,
      48'h03_2000_0001_02, 48'h06_2000_0000_02, 48'h05_0000_0000_01, 48'h10_0000_0000_01,
      48'h08_0001_0000_01, 48'h08_0100_0000_01};
   int n_errors = 0, total_checks = 0, cyc = 0, n2 = 0, nw = 0;
   mbrf_link_if l1();
   mbrf_link_if l2();
   mbrf_master mbrf_master_i (.clk(clk), .rst_n(rst_n), .link(l1), .start(start), .q_slave(q_slave),
      .q_func(q_func), .q_field_a(fa), .q_field_b(fb), .busy(m_busy), .done(done), .crc_ok(crc_ok),
      .rx_byte(rx_byte), .rx_valid(rx_valid));
   mbrf_slave mbrf_slave_i (.clk(clk), .rst_n(rst_n), .link(l1), .slave_addr(s_addr), .busy(s_busy),
      .wr_addr(wr_addr), .wr_data(wr_data), .wr_strobe(wr_strobe));
   mbrf_slave mbrf_slave_i_b (.clk(clk), .rst_n(rst_n), .link(l2), .slave_addr(8'h01), .busy(),
      .wr_addr(), .wr_data(), .wr_strobe());
   mbrf_asserts mbrf_asserts_i (.clk(clk), .rst_n(rst_n), .q_data(l1.q_data), .q_valid(l1.q_valid),
      .q_last(l1.q_last), .r_data(l1.r_data), .r_valid(l1.r_valid), .r_last(l1.r_last));
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (rx_valid)
         rq.push_back(rx_byte);
      if (done)
         got_done = 1'b1;
      if (s_busy === 1'b1)
         s_seen = 1'b1;
      if (wr_strobe)
      begin
         wa = wr_addr;
         wd = wr_data;
         nw++;
      end
      if (l2.r_valid)
         n2++;
      if (cyc == 20000)
      begin
         n_errors++;
         end_sim();
      end
   end
   function automatic logic [15:0] crc16(input logic [7:0] m[$]);
      logic [15:0] r;
      r = 16'hFFFF;
      foreach (m[i])
      begin
         r = r ^ {8'h00, m[i]};
         for (int j = 0; j < 8; j++)
            r = r[0] ? (r >> 1) ^ 16'hA001 : r >> 1;
      end
      return r;
   endfunction
   task automatic end_sim();
      if (n_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // A quiet query waits out the whole bound and expects neither reply nor done.
   task automatic run(input logic [7:0] sa, input logic [7:0] fn, input logic [15:0] a, input logic [15:0] b,
      input bit quiet);
      rq.delete();
      got_done = 1'b0;
      s_seen = 1'b0;
      @(negedge clk);
      start = 1'b1;
      q_slave = sa;
      q_func = fn;
      fa = a;
      fb = b;
      @(negedge clk);
      start = 1'b0;
      `CHK(m_busy, 1'b1)
      for (int k = 0; k < 200 && !(got_done === 1'b1); k++)
         @(negedge clk);
      `CHK(got_done, !quiet)
      `CHK(s_seen, !quiet)
      `CHK(m_busy, 1'b0)
      `CHK(s_busy, 1'b0)
      if (quiet)
         `CHK(rq.size(), 0)
   endtask
   task automatic chk_reply(input logic [7:0] m[$]);
      c = crc16(m);
      m.push_back(c[7:0]);
      m.push_back(c[15:8]);
      `CHK(rq.size(), m.size())
      foreach (m[i])
         `CHK(rq[i], m[i])
      `CHK(crc_ok, 1'b1)
   endtask
   task automatic send2(input logic [7:0] m[$]);
      n2 = 0;
      foreach (m[i])
      begin
         @(negedge clk);
         l2.q_data = m[i];
         l2.q_valid = 1'b1;
         l2.q_last = (i == m.size() - 1);
      end
      @(negedge clk);
      l2.q_valid = 1'b0;
      l2.q_last = 1'b0;
      l2.q_data = ~l2.q_data;
      repeat (60) @(negedge clk);
   endtask
   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      start = 1'b0;
      q_slave = 8'h00;
      q_func = 8'h00;
      fa = 16'h0000;
      fb = 16'h0000;
      s_addr = 8'h01;
      l2.q_data = 8'h00;
      l2.q_valid = 1'b0;
      l2.q_last = 1'b0;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      // with no paired write, halves go back to back.
      for (int i = 0; i < 4; i++)
      begin
         run(8'h01, FN_WRITE_ONE, 16'h0480 + 16'(i), dv[i], 1'b0);
         chk_reply({8'h01, 8'h06, 8'h04, 8'(8'h80 + i), dv[i][15:8], dv[i][7:0]});
         `CHK(wa, 16'h0480 + 16'(i))
         `CHK(wd, dv[i])
      end
      // Both halves of each wide value are fetched in one query.
      run(8'h01, FN_READ_HOLD, 16'h0480, 16'h0004, 1'b0);
      chk_reply({8'h01, 8'h03, 8'h08, 8'h00, 8'h00, 8'h00, 8'h64, 8'h00, 8'h00, 8'h0F, 8'hA0});
      `CHK(rq[11], 8'hE1)
      `CHK(rq[12], 8'h97)
      e = {8'h01, 8'h03, 8'h20};
      for (int i = 0; i < 16; i++)
      begin
         run(8'h01, FN_WRITE_ONE, 16'h1FEF + 16'(i), {8'(~i), 8'(i)}, 1'b0);
         e.push_back(8'(~i));
         e.push_back(8'(i));
      end
      run(8'h01, FN_READ_HOLD, 16'h1FEF, 16'h0010, 1'b0);
      chk_reply(e);
      s_addr = 8'h03;
      run(8'h03, FN_DIAG, 16'h0000, 16'h1234, 1'b0);
      chk_reply({8'h03, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34});
      `CHK(rq[6], 8'hEC)
      `CHK(rq[7], 8'h9E)
      run(8'h01, FN_WRITE_ONE, 16'h0480, 16'hFFFF, 1'b1);
      run(8'h00, FN_WRITE_ONE, 16'h0481, 16'hFFFF, 1'b1);
      s_addr = 8'h01;
      // Dropped writes must leave the stored values untouched.
      run(8'h01, FN_READ_HOLD, 16'h0480, 16'h0002, 1'b0);
      chk_reply({8'h01, 8'h03, 8'h04, 8'h00, 8'h00, 8'h00, 8'h64});
      foreach (xt[i])
      begin
         run(8'h01, xt[i][47:40], xt[i][39:24], xt[i][23:8], 1'b0);
         chk_reply({8'h01, xt[i][47:40] | 8'h80, xt[i][7:0]});
      end
      `CHK(nw, 20)
      g = {8'h01, 8'h08, 8'h00, 8'h00, 8'h55, 8'hAA};
      c = crc16(g);
      send2({g, c[7:0], ~c[15:8]});
      `CHK(n2, 0)
      h = {8'h01, 8'h08, 8'h00, 8'h00, 8'h55};
      c = crc16(h);
      send2({h, c[7:0], c[15:8]});
      `CHK(n2, 0)
      c = crc16(g);
      send2({g, c[7:0], c[15:8]});
      `CHK(n2, 8)
      end_sim();
   end
endmodule
